// file: core/ssr_pkg.sv
/*
 shared constants for the serial position readout: status codes, bit counts, timing.
 assumes a 100 MHz system clock and a separate link clock for the serial side.
*/
package ssr_pkg;
    // ----------------------------------------------------------------
    // status codes
    // ----------------------------------------------------------------
    localparam logic [1:0] STAT_OK = 2'h0;
    localparam logic [1:0] STAT_LINK = 2'h1;
    localparam logic [1:0] STAT_CFG = 2'h2;
    // ----------------------------------------------------------------
    // widths and defaults
    // ----------------------------------------------------------------
    localparam int POS_W = 32;
    localparam int CNT_W = 6;
    localparam logic [5:0] MAX_BITS = 6'h20;
    localparam logic [5:0] DEF_REV_BITS = 6'h0c;
    localparam logic [5:0] DEF_TURN_BITS = 6'h0d;
    // pause after last rising clock edge, in link clock periods
    localparam logic [7:0] DEF_PAUSE = 8'h50;
    // link timeout in ns, then system cycles: a requested frame must finish within this long
    localparam int LINK_TIMEOUT_NS = 20000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

// file: core/ssr_link.sv
/*
 link side frame engine of the serial position readout, on the link clock.
 assumes lnk_rstn is synchronously released in the link domain by the parent.
*/
`timescale 1ns/10ps
module ssr_link #(
    parameter int POS_W = 32
) (
    input wire logic lnk_clock,
    input wire logic lnk_rstn,
    input wire logic start_tgl,
    input wire logic [5:0] total_bits,
    input wire logic [7:0] pause_len,
    input wire logic data_in,
    output logic enc_clock,
    output logic [POS_W-1:0] frame_word,
    output logic frame_ok,
    output logic done_tgl
);
    // ----------------------------------------------------------------
    // frame states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HIGH = 4'b0010,
        ST_LOW = 4'b0100,
        ST_PAUSE = 4'b1000
    } ssr_state_e;

    ssr_state_e state_r;
    logic [1:0] req_sync_r;
    logic req_seen_r;
    logic [1:0] data_sync_r;
    logic [5:0] bit_r;
    logic [7:0] pause_r;
    logic [POS_W-1:0] shift_r;
    logic enc_clock_r;
    logic done_r;
    logic ok_r;
    logic [POS_W-1:0] word_r;
    logic tail_r;

    wire logic start_req = req_sync_r[1] ^ req_seen_r;
    wire logic last_bit = (bit_r == total_bits);
    wire logic data_bit = data_sync_r[1];

    // request toggle and data line crossing into link domain
    always_ff @(posedge lnk_clock or negedge lnk_rstn) begin
        if (!lnk_rstn) begin
            req_sync_r <= 2'h0;
            data_sync_r <= 2'h3;
        end else begin
            req_sync_r <= {req_sync_r[0], start_tgl};
            data_sync_r <= {data_sync_r[0], data_in};
        end
    end

    // one half period per state step; data sampled on each rising edge
    always_ff @(posedge lnk_clock or negedge lnk_rstn) begin
        if (!lnk_rstn) begin
            state_r <= ST_IDLE;
            req_seen_r <= 1'b0;
            bit_r <= 6'h0;
            pause_r <= 8'h0;
            shift_r <= '0;
            enc_clock_r <= 1'b1;
            done_r <= 1'b0;
            ok_r <= 1'b0;
            word_r <= '0;
            tail_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_req) begin
                        req_seen_r <= req_sync_r[1];
                        bit_r <= 6'h0;
                        enc_clock_r <= 1'b0;
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // two sync flops delay the bit of fall k to this state at count k; fall 1 is the start bit
                    if (bit_r >= 6'h2) begin
                        shift_r <= {shift_r[POS_W-2:0], data_bit};
                    end
                    enc_clock_r <= 1'b1;
                    state_r <= ST_HIGH;
                end
                ST_HIGH: begin
                    if (last_bit) begin
                        tail_r <= 1'b1;
                        pause_r <= pause_len;
                        state_r <= ST_PAUSE;
                    end else begin
                        bit_r <= bit_r + 6'h1;
                        enc_clock_r <= 1'b0;
                        state_r <= ST_LOW;
                    end
                end
                ST_PAUSE: begin
                    // no new frame until pause has run out
                    if (tail_r) begin
                        // last data bit only now leaves the synchroniser
                        shift_r <= {shift_r[POS_W-2:0], data_bit};
                        tail_r <= 1'b0;
                    end else if (pause_r != 8'h0) begin
                        pause_r <= pause_r - 8'h1;
                    end else begin
                        // line must have risen after pause, else link is dead
                        ok_r <= data_bit;
                        word_r <= shift_r;
                        done_r <= ~done_r;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign enc_clock = enc_clock_r;
    assign frame_word = word_r;
    assign frame_ok = ok_r;
    assign done_tgl = done_r;
endmodule

// file: core/ssr_readout.sv
/*
 top of the serial position readout: config check, frame requests, publish and status.
 assumes host_update_cycle is a one-cycle pulse on clock; encoder data on a pin.
*/
`timescale 1ns/10ps
// Contract
// - status reads 1 when the encoder is missing or the link is broken and the bit counts are valid.
// - status reads 2 when revolution plus within-turn bit counts exceed 32.
// - while any error holds, the published position holds its last valid value.
// - once the link is healthy again, the position refreshes every update cycle.
// - status encodes 0 no error, 1 link fault, 2 wrong parameter setting.
// - after the last rising clock edge the clock stays high for a pause and no frame starts within it.
module ssr_readout #(
    parameter int POS_W = ssr_pkg::POS_W,
    parameter int TIMEOUT_CYC = ssr_pkg::LINK_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic lnk_clock,
    input wire logic host_update_cycle,
    input wire logic [5:0] revolution_bit_count,
    input wire logic [5:0] within_turn_bit_count,
    input wire logic [7:0] pause_len,
    input wire logic enc_data,
    output logic enc_clock,
    output logic [POS_W-1:0] published_position,
    output logic [1:0] link_status_code,
    output logic position_fresh
);
    // ----------------------------------------------------------------
    // configuration check
    // ----------------------------------------------------------------
    logic [6:0] bit_sum;
    logic cfg_bad;
    logic [5:0] total_bits;
    // seven bits so two full six-bit counts cannot wrap
    assign bit_sum = {1'b0, revolution_bit_count} + {1'b0, within_turn_bit_count};
    assign cfg_bad = bit_sum > {1'b0, ssr_pkg::MAX_BITS};
    // a bad setting never starts frames, so the clamp to MAX_BITS only keeps total_bits in range
    assign total_bits = cfg_bad ? ssr_pkg::MAX_BITS : bit_sum[5:0];

    // ----------------------------------------------------------------
    // reset release into link domain
    // ----------------------------------------------------------------
    logic [1:0] lrst_r;
    logic lnk_rstn;
    always_ff @(posedge lnk_clock or negedge resetn) begin
        if (!resetn) begin
            lrst_r <= 2'h0;
        end else begin
            lrst_r <= {lrst_r[0], 1'b1};
        end
    end
    assign lnk_rstn = lrst_r[1];

    // ----------------------------------------------------------------
    // frame requests and completion
    // ----------------------------------------------------------------
    logic start_tgl_r;
    logic busy_r;
    logic [2:0] done_sync_r;
    logic done_tgl;
    logic frame_ok;
    logic [POS_W-1:0] frame_word;
    logic done_pulse;

    ssr_link #(
        .POS_W(POS_W)
    ) u_link (
        .lnk_clock(lnk_clock),
        .lnk_rstn(lnk_rstn),
        .start_tgl(start_tgl_r),
        .total_bits(total_bits),
        .pause_len(pause_len),
        .data_in(enc_data),
        .enc_clock(enc_clock),
        .frame_word(frame_word),
        .frame_ok(frame_ok),
        .done_tgl(done_tgl)
    );

    // done toggle crossing; word and ok are stable for many cycles around it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done_sync_r <= 3'h0;
        end else begin
            done_sync_r <= {done_sync_r[1:0], done_tgl};
        end
    end
    assign done_pulse = done_sync_r[2] ^ done_sync_r[1];

    wire logic start_now = host_update_cycle && !busy_r && !cfg_bad;

    // one frame per update cycle; a busy link skips the request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            start_tgl_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            if (start_now) begin
                start_tgl_r <= ~start_tgl_r;
            end
            if (start_now) begin
                busy_r <= 1'b1;
            end else if (done_pulse) begin
                busy_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // link watchdog
    // ----------------------------------------------------------------
    localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
    logic [TMO_W-1:0] tmo_r;
    logic link_bad_r;
    wire logic tmo_hit = (tmo_r == TMO_W'(TIMEOUT_CYC));
    // status must see the same link verdict as the publish step, or fresh and a stale fault meet
    wire logic link_bad_nxt = done_pulse ? !frame_ok : (link_bad_r || tmo_hit);
    // a missing frame answer counts as broken link too
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tmo_r <= '0;
            link_bad_r <= 1'b0;
        end else begin
            if (!busy_r || done_pulse) begin
                tmo_r <= '0;
            end else if (!tmo_hit) begin
                tmo_r <= tmo_r + TMO_W'(1);
            end
            link_bad_r <= link_bad_nxt;
        end
    end

    // ----------------------------------------------------------------
    // publish and status
    // ----------------------------------------------------------------
    logic [POS_W-1:0] pos_r;
    logic [1:0] stat_r;
    logic fresh_r;
    logic [1:0] stat_nxt;
    logic [POS_W-1:0] mask;
    // config fault takes priority since no frame can run
    assign stat_nxt = cfg_bad ? ssr_pkg::STAT_CFG : (link_bad_nxt ? ssr_pkg::STAT_LINK : ssr_pkg::STAT_OK);
    // word is msb first: revolution bits shift in first, land on top
    assign mask = (POS_W'(1) << total_bits) - POS_W'(1);
    wire logic good_frame = done_pulse && frame_ok && !cfg_bad;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pos_r <= '0;
            stat_r <= ssr_pkg::STAT_OK;
            fresh_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            fresh_r <= good_frame;
            if (good_frame) begin
                pos_r <= (total_bits == ssr_pkg::MAX_BITS) ? frame_word : (frame_word & mask);
            end
        end
    end

    assign published_position = pos_r;
    assign link_status_code = stat_r;
    assign position_fresh = fresh_r;
endmodule

// file: bench/ssr_readout_monitor.sv
/*
 checker for the serial position readout, watching top ports only.
 assumes counts are static while a frame runs.
*/
`timescale 1ns/10ps
module ssr_readout_monitor #(
    parameter int POS_W = 32,
    parameter int TIMEOUT_CYC = 2000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic lnk_clock,
    input wire logic host_update_cycle,
    input wire logic [5:0] revolution_bit_count,
    input wire logic [5:0] within_turn_bit_count,
    input wire logic [7:0] pause_len,
    input wire logic enc_data,
    input wire logic enc_clock,
    input wire logic [POS_W-1:0] published_position,
    input wire logic [1:0] link_status_code,
    input wire logic position_fresh
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // sum kept 7 bits wide so 63+63 cannot wrap
    wire [6:0] sum = {1'b0, revolution_bit_count} + {1'b0, within_turn_bit_count};
    wire sum_bad = sum > 7'h20;
    logic [7:0] hi_cnt_r;
    // link cycles the encoder clock has stayed high, saturating
    always_ff @(posedge lnk_clock or negedge resetn) begin
        if (!resetn) hi_cnt_r <= 8'h0;
        else hi_cnt_r <= !enc_clock ? 8'h0 : (hi_cnt_r == 8'hff ? hi_cnt_r : hi_cnt_r + 8'h1);
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_CFG_CODE: assert property (@(posedge clock) disable iff (!resetn)
        sum_bad [*3] |-> link_status_code == ssr_pkg::STAT_CFG) else $error("bad counts not flagged");
    AST_CFG_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        link_status_code == ssr_pkg::STAT_CFG && !sum_bad |-> ##[1:3] link_status_code != ssr_pkg::STAT_CFG)
        else $error("config error stuck");
    AST_CODE_SET: assert property (@(posedge clock) disable iff (!resetn)
        link_status_code != 2'h3) else $error("undefined status code");
    AST_ERR_NO_FRESH: assert property (@(posedge clock) disable iff (!resetn)
        position_fresh |-> link_status_code == ssr_pkg::STAT_OK) else $error("refresh during error");
    AST_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        $changed(published_position) |-> position_fresh || $past(position_fresh)) else $error("position moved");
    AST_FRESH_PULSE: assert property (@(posedge clock) disable iff (!resetn)
        position_fresh |=> !position_fresh) else $error("fresh longer than one cycle");
    AST_WIDTH: assert property (@(posedge clock) disable iff (!resetn)
        position_fresh && !sum_bad |-> (published_position >> sum) == '0) else $error("bits above width");
    AST_PAUSE: assert property (@(posedge lnk_clock) disable iff (!resetn)
        $fell(enc_clock) |-> hi_cnt_r <= 8'h2 || hi_cnt_r >= pause_len) else $error("frame inside pause");
    AST_RESET_VAL: assert property (@(posedge clock)
        !resetn |-> published_position == '0 && link_status_code == ssr_pkg::STAT_OK && !position_fresh)
        else $error("reset values wrong");
endmodule
bind ssr_readout ssr_readout_monitor #(.POS_W(POS_W), .TIMEOUT_CYC(TIMEOUT_CYC)) i_mon (.*);

// file: bench/ssr_enc_model.sv
/*
 behavioural absolute encoder on the serial link.
 assumes the readout drives enc_clock idle high; alive low models a cut line.
*/
`timescale 1ns/10ps
module ssr_enc_model #(
    parameter int TAIL_NS = 400
) (
    input wire logic enc_clock,
    input wire logic alive,
    input wire logic [6:0] total,
    input wire logic [31:0] word,
    output logic enc_data
);
    int cnt = 0;
    logic d = 1'b1;
    // a cut line reads low, so no frame ever ends high
    assign enc_data = alive ? d : 1'b0;
    // next bit on each fall, msb first, start low on the first fall
    always @(negedge enc_clock) begin
        cnt = cnt + 1;
        d = (cnt == 1) ? 1'b0 : word[total + 1 - cnt];
    end
    // line low for a short tail after the last rise, then idle high
    always @(posedge enc_clock) begin
        if (cnt == total + 1) begin
            cnt = 0;
            d = 1'b0;
            #(TAIL_NS) d = 1'b1;
        end
    end
endmodule

// file: bench/ssr_readout_test.sv
/*
 testbench of the serial position readout: table of frames, then reset.
 assumes the encoder model answers every frame while alive.
*/
`timescale 1ns/10ps
module ssr_readout_test;
    typedef struct packed {logic [5:0] rv; logic [5:0] tn; logic al; logic [31:0] w; logic [1:0] st;} ssr_row_s;
    // ----------------------------------------
    // signals and rows
    // ----------------------------------------
    logic clock = 1'b0, lnk_clock = 1'b0, resetn = 1'b0, huc = 1'b0, alive = 1'b1, fr;
    logic [5:0] rv = 6'h0c, tn = 6'h0d;
    logic [31:0] word = 32'h0, last = 32'h0, mask;
    logic enc_data, enc_clock, position_fresh;
    logic [31:0] pos;
    logic [1:0] status;
    int miscompares = 0, comparisons = 0;
    ssr_row_s rows [8] = '{'{6'h0c, 6'h0d, 1'b1, 32'h0123_4567, 2'h0}, '{6'h10, 6'h10, 1'b1, 32'hdead_beef, 2'h0},
        '{6'h14, 6'h0d, 1'b1, 32'h1111_1111, 2'h2}, '{6'h00, 6'h08, 1'b1, 32'h0000_a55a, 2'h0},
        '{6'h0c, 6'h0d, 1'b0, 32'h0fff_ffff, 2'h1}, '{6'h14, 6'h0d, 1'b0, 32'h0, 2'h2},
        '{6'h0c, 6'h0d, 1'b1, 32'h0155_aa33, 2'h0}, '{6'h01, 6'h01, 1'b1, 32'h0000_0003, 2'h0}};
    // ----------------------------------------
    // clocks, design and encoder
    // ----------------------------------------
    initial forever #5 clock = ~clock;
    initial begin
        #3;
        forever #32 lnk_clock = ~lnk_clock;
    end
    ssr_readout #(.TIMEOUT_CYC(1000)) i_dut (.clock(clock), .resetn(resetn), .lnk_clock(lnk_clock),
        .host_update_cycle(huc), .revolution_bit_count(rv), .within_turn_bit_count(tn), .pause_len(8'h10),
        .enc_data(enc_data), .enc_clock(enc_clock), .published_position(pos), .link_status_code(status),
        .position_fresh(position_fresh));
    ssr_enc_model i_enc (.enc_clock(enc_clock), .alive(alive), .total({1'b0, rv} + {1'b0, tn}), .word(word),
        .enc_data(enc_data));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one request, then a bounded wait for the refresh pulse
    task automatic frame();
        @(posedge clock);
        #1 huc = 1'b1;
        @(posedge clock);
        #1 huc = 1'b0;
        fr = 1'b0;
        for (int k = 0; k < 1200 && !fr; k++) begin
            @(posedge clock);
            #1 fr = (position_fresh === 1'b1);
        end
        repeat (4) @(posedge clock);
        #1;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        #300000 miscompares++;
        end_sim();
    end
    initial begin
        // held long enough for three link edges
        repeat (20) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (150) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rv = rows[i].rv;
            tn = rows[i].tn;
            alive = rows[i].al;
            word = rows[i].w;
            mask = 32'((64'h1 << (rv + tn)) - 64'h1);
            frame();
            if (rows[i].st == 2'h0) last = word & mask;
            chk("status", {30'h0, status}, {30'h0, rows[i].st});
            chk("position", pos, last);
            chk("fresh", {31'h0, fr}, {31'h0, rows[i].st == 2'h0});
            $display("row %0d done", i);
        end
        // reset after the last row clears position and status at once and sets enc_clock high
        resetn = 1'b0;
        #1;
        chk("reset", {pos[29:0], status}, 32'h0);
        chk("enc_clock", {31'h0, enc_clock}, 32'h1);
        $display("reset test done");
        end_sim();
    end
endmodule
